// ---- hdl/fpmc_sync.sv ----
// three stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ns
module fpmc_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1;
  logic s2;
  logic s3;

  // capture chain, first stage feeds only the second
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // level changes once stages two and three agree
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      level_out <= RESET_LEVEL;
    end else if (s2 == s3) begin
      level_out <= s3;
    end
  end
endmodule : fpmc_sync

// ---- hdl/fpmc_top.sv ----
// flash program mode controller: offline and background flash programming, refresh
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "fpmc_cfg.svh"
module fpmc_top import fpmc_pkg::*; #(
  parameter int INIT_CYCLES = `FPMC_INIT_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // host command port
  input  wire logic        cmd_valid_in,
  input  wire logic [2:0]  cmd_code_in,
  input  wire logic [2:0]  cmd_sect_in,
  output logic             cmd_ready_out,
  output logic             cmd_err_out,
  // flash array
  output logic             fl_req_out,
  output logic             fl_erase_out,
  output logic [2:0]       fl_sect_out,
  input  wire logic        fl_done_in,
  // image size and user sector role
  input  wire logic [`FPMC_SIZE_W-1:0] image_words_in,
  input  wire logic        overflow_block_in,
  input  wire logic        ufm_ebr_in,
  output fpmc_ufm_role_t   ufm_role_out,
  // SRAM configuration load
  output logic             cfg_load_out,
  output logic             cfg_src_ext_out,
  input  wire logic        cfg_loaded_in,
  // status pins, init status is open drain
  input  wire logic        init_status_pin_in,
  output logic             init_status_pin_out,
  output logic             init_status_pin_oe_out,
  output logic             done_out,
  // user logic and PLL control
  output logic             user_run_out,
  output logic             pll_right_rst_out,
  // internal on-chip bus flash access
  input  wire logic        ib_req_in,
  output logic             ib_grant_out,
  output logic             ib_err_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fpmc_state_t state;
  fpmc_state_t next_state;
  logic [15:0] init_cnt;
  logic        init_timer_done;
  logic        init_pin_level;
  logic        accept;
  logic        cmd_off;
  logic        cmd_bg;
  logic        cmd_ref;
  logic [2:0]  next_mask;
  logic        op_erase;
  logic        over_cfg;
  logic        over_all;

  // the timer must outlast the pin synchroniser, or a stale high level ends init early
  if (INIT_CYCLES < 4 || INIT_CYCLES > 65535) begin : g_bad_init_cycles
    $error("INIT_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  fpmc_sync #(
    .RESET_LEVEL (1'b0) // the block pulls the pin low itself during reset
  ) u_init_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (init_status_pin_in),
    .level_out (init_pin_level)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign cmd_ready_out = (state == FPMC_ST_USER);
  assign accept        = cmd_valid_in & cmd_ready_out;
  assign cmd_off = (cmd_code_in == FPMC_CMD_OFF_ERASE) | (cmd_code_in == FPMC_CMD_OFF_PROG);
  assign cmd_bg  = (cmd_code_in == FPMC_CMD_BG_ERASE) | (cmd_code_in == FPMC_CMD_BG_PROG);
  assign cmd_ref = (cmd_code_in == FPMC_CMD_REFRESH);

  // sector mask: empty request takes the mode default, background never touches feature row
  always_comb begin
    next_mask = 3'h0;
    if (cmd_off) begin
      next_mask = (cmd_sect_in == 3'h0) ? `FPMC_MASK_OFFLINE_DEF : cmd_sect_in;
    end else if (cmd_bg) begin
      next_mask = ((cmd_sect_in == 3'h0) ? `FPMC_MASK_BG_DEF : cmd_sect_in)
                  & `FPMC_MASK_BG_DEF;
    end
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      FPMC_ST_INIT: begin
        if (init_timer_done && init_pin_level) begin
          next_state = FPMC_ST_LOAD;
        end
      end
      FPMC_ST_LOAD: begin
        if (cfg_loaded_in) begin
          next_state = FPMC_ST_USER;
        end
      end
      FPMC_ST_USER: begin
        if (accept && cmd_off) begin
          next_state = FPMC_ST_OFFL;
        end else if (accept && cmd_bg) begin
          next_state = FPMC_ST_BG;
        end else if (accept && cmd_ref) begin
          next_state = FPMC_ST_INIT;
        end
      end
      FPMC_ST_OFFL: begin
        if (fl_done_in) begin
          next_state = FPMC_ST_USER;
        end
      end
      FPMC_ST_BG: begin
        if (fl_done_in) begin
          next_state = FPMC_ST_USER;
        end
      end
      default: begin
        next_state = FPMC_ST_INIT;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= FPMC_ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // illegal command code reported for one cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cmd_err_out <= 1'b0;
    end else begin
      cmd_err_out <= accept & ~(cmd_off | cmd_bg | cmd_ref);
    end
  end

  // ----------------------------------------------------------------
  // initialization timer and status pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in || state != FPMC_ST_INIT) begin
      init_cnt <= 16'h0000;
    end else if (!init_timer_done) begin
      init_cnt <= init_cnt + 16'h0001;
    end
  end
  assign init_timer_done = (init_cnt >= 16'(INIT_CYCLES));

  // init status driven low while clearing, done high in user operation and background programming
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      init_status_pin_oe_out <= 1'b1;
      done_out               <= 1'b0;
    end else begin
      init_status_pin_oe_out <= (next_state == FPMC_ST_INIT) & ~init_timer_done;
      done_out <= (next_state == FPMC_ST_USER) | (next_state == FPMC_ST_BG);
    end
  end
  assign init_status_pin_out = 1'b0; // open drain, only ever pulls low

  // ----------------------------------------------------------------
  // user logic run enable and PLL reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      user_run_out      <= 1'b0;
      pll_right_rst_out <= 1'b0;
    end else begin
      user_run_out <= (next_state == FPMC_ST_USER) | (next_state == FPMC_ST_BG);
      pll_right_rst_out <= (next_state == FPMC_ST_BG) &
                           (((state == FPMC_ST_USER) & (cmd_code_in == FPMC_CMD_BG_ERASE))
                            | ((state == FPMC_ST_BG) & op_erase));
    end
  end
  // the left PLL is given no reset at all here, it keeps running

  // ----------------------------------------------------------------
  // flash request
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fl_req_out   <= 1'b0;
      fl_erase_out <= 1'b0;
      fl_sect_out  <= 3'h0;
      op_erase     <= 1'b0;
    end else begin
      fl_req_out <= accept & (cmd_off | cmd_bg);
      if (accept && (cmd_off || cmd_bg)) begin
        op_erase     <= (cmd_code_in == FPMC_CMD_OFF_ERASE) | (cmd_code_in == FPMC_CMD_BG_ERASE);
        fl_erase_out <= (cmd_code_in == FPMC_CMD_OFF_ERASE) | (cmd_code_in == FPMC_CMD_BG_ERASE);
        fl_sect_out  <= next_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // image placement and configuration load
  // ----------------------------------------------------------------
  assign over_cfg = (image_words_in > `FPMC_CFG_WORDS);
  assign over_all = ({1'b0, image_words_in} > ({1'b0, `FPMC_CFG_WORDS} + {1'b0, `FPMC_UFM_WORDS}));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ufm_role_out    <= FPMC_UFM_GENERAL;
      cfg_src_ext_out <= 1'b0;
      cfg_load_out    <= 1'b0;
    end else begin
      if (over_cfg && !overflow_block_in && !over_all) begin
        ufm_role_out <= FPMC_UFM_CFGEXT;
      end else begin
        ufm_role_out <= ufm_ebr_in ? FPMC_UFM_EBR : FPMC_UFM_GENERAL;
      end
      cfg_src_ext_out <= over_all | (over_cfg & overflow_block_in);
      // SRAM is written only on the way out of initialization
      cfg_load_out <= (state == FPMC_ST_INIT) & (next_state == FPMC_ST_LOAD);
    end
  end

  // ----------------------------------------------------------------
  // internal bus access gate
  // ----------------------------------------------------------------
  assign ib_grant_out = ib_req_in & (state == FPMC_ST_USER);
  assign ib_err_out   = ib_req_in & (state != FPMC_ST_USER);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence off_start_s;
    accept && cmd_off;
  endsequence
  sequence bg_start_s;
    accept && cmd_bg;
  endsequence

  offline_halts_user_a: assert property (off_start_s |=> ##1 !user_run_out)
    else $error("user logic still running in offline mode");
  offline_mask_a: assert property (accept && cmd_off && cmd_sect_in == 3'h0
      |=> fl_req_out && fl_sect_out == 3'h7)
    else $error("offline default mask wrong");
  bg_keeps_user_a: assert property (bg_start_s ##1 state == FPMC_ST_BG
      |-> user_run_out)
    else $error("user logic stopped in background mode");
  refresh_init_a: assert property (accept && cmd_ref |=> ##1 !done_out
      && init_status_pin_oe_out)
    else $error("refresh did not re-enter initialization");
  bg_no_feature_a: assert property (bg_start_s |=> !fl_sect_out[2])
    else $error("background touched feature row");
  pll_right_a: assert property ((bg_start_s and cmd_code_in == FPMC_CMD_BG_ERASE)
      |=> pll_right_rst_out)
    else $error("right PLL not reset in background erase");
  overflow_role_a: assert property (over_cfg && !overflow_block_in && !over_all
      |=> ufm_role_out == FPMC_UFM_CFGEXT)
    else $error("overflow into user sector missed");
  ext_source_a: assert property (over_all |=> cfg_src_ext_out)
    else $error("oversize image not sent to external flash");
  ib_offline_a: assert property (state == FPMC_ST_OFFL |-> !ib_grant_out)
    else $error("internal bus granted in offline mode");
  sram_hold_a: assert property (state == FPMC_ST_BG |=> !cfg_load_out)
    else $error("SRAM reloaded during background programming");
endmodule : fpmc_top

// ---- include/fpmc_cfg.svh ----
// constants for the flash program mode controller
`ifndef FPMC_CFG_SVH
`define FPMC_CFG_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define FPMC_CLK_PERIOD_NS 20
`define FPMC_INIT_LOW_NS   2000
`define FPMC_INIT_CYCLES   ((`FPMC_INIT_LOW_NS + `FPMC_CLK_PERIOD_NS - 1) / `FPMC_CLK_PERIOD_NS)
// ----------------------------------------------------------------
// sector mask bit positions
// ----------------------------------------------------------------
`define FPMC_SECT_CFG  0
`define FPMC_SECT_UFM  1
`define FPMC_SECT_FEAT 2
`define FPMC_MASK_OFFLINE_DEF 3'h7
`define FPMC_MASK_BG_DEF      3'h3
// ----------------------------------------------------------------
// sector sizes in words
// ----------------------------------------------------------------
`define FPMC_CFG_WORDS 24'h008000
`define FPMC_UFM_WORDS 24'h002000
`define FPMC_SIZE_W    24
`endif

// ---- include/fpmc_pkg.sv ----
// types for the flash program mode controller
package fpmc_pkg;
  // ----------------------------------------------------------------
  // host commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FPMC_CMD_OFF_ERASE = 3'h1,
    FPMC_CMD_OFF_PROG  = 3'h2,
    FPMC_CMD_BG_ERASE  = 3'h3,
    FPMC_CMD_BG_PROG   = 3'h4,
    FPMC_CMD_REFRESH   = 3'h5
  } fpmc_cmd_t;
  // ----------------------------------------------------------------
  // controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FPMC_ST_INIT = 5'h01,
    FPMC_ST_LOAD = 5'h02,
    FPMC_ST_USER = 5'h04,
    FPMC_ST_OFFL = 5'h08,
    FPMC_ST_BG   = 5'h10
  } fpmc_state_t;
  // ----------------------------------------------------------------
  // role of the user flash sector
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPMC_UFM_GENERAL = 2'h0,
    FPMC_UFM_EBR     = 2'h1,
    FPMC_UFM_CFGEXT  = 2'h2
  } fpmc_ufm_role_t;
endpackage : fpmc_pkg

// ---- testbench/flash_program_mode_control_tb.sv ----
// self-checking bench for the flash program mode controller
`timescale 1ns/1ns
`include "fpmc_cfg.svh"
module flash_program_mode_control_tb import fpmc_pkg::*;;
  logic mclk_in = 1'h0, rst_in = 1'h1, cmd_valid = 1'h0, ib_req = 1'h0, ext_low = 1'h0;
  logic [2:0] cmd_code = 3'h0, cmd_sect = 3'h0;
  logic [23:0] image_words = 24'h000100;
  logic blk = 1'h0, embedded_block_ram = 1'h0;
  logic [3:0] lat = 4'h0;
  logic ready, err, fl_req, fl_erase, fl_done, cfg_load, src_ext, cfg_loaded, oe, done;
  logic run, pll, grant, ib_err;
  logic [2:0] fl_sect;
  logic [7:0] loads, loads0;
  fpmc_ufm_role_t role;
  int fail_count = 0, samples_checked = 0;
  // ------------------------------------------------------------
  // clock, open drain init pin with pull-up, design and partner
  // ------------------------------------------------------------
  always #10 mclk_in = ~mclk_in;
  fpmc_top #(.INIT_CYCLES(4)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_sect_in(cmd_sect),
    .cmd_ready_out(ready), .cmd_err_out(err), .fl_req_out(fl_req), .fl_erase_out(fl_erase),
    .fl_sect_out(fl_sect), .fl_done_in(fl_done), .image_words_in(image_words),
    .overflow_block_in(blk), .ufm_ebr_in(embedded_block_ram), .ufm_role_out(role), .cfg_load_out(cfg_load),
    .cfg_src_ext_out(src_ext), .cfg_loaded_in(cfg_loaded),
    .init_status_pin_in(~(oe | ext_low)), .init_status_pin_out(), .init_status_pin_oe_out(oe),
    .done_out(done), .user_run_out(run), .pll_right_rst_out(pll), .ib_req_in(ib_req),
    .ib_grant_out(grant), .ib_err_out(ib_err));
  fpmc_host_model host (.mclk_in(mclk_in), .rst_in(rst_in), .lat_in(lat), .fl_req_in(fl_req),
    .fl_done_out(fl_done), .cfg_load_in(cfg_load), .cfg_loaded_out(cfg_loaded),
    .load_count_out(loads));
  // ------------------------------------------------------------
  // shared compare, verdict, command and wait tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic wait_ready();
    int n;
    for (n = 0; n < 400 && ready !== 1'h1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    if (ready !== 1'h1) begin
      fail_count++;
      $display("CHECK FAILED ready wait expected 1 seen %b", ready);
      tally_and_finish();
    end
  endtask : wait_ready
  // holds the request until the edge that takes it, returns 1 ns after the answer cycle
  task automatic issue(input logic [2:0] code, input logic [2:0] sect);
    @(posedge mclk_in);
    cmd_valid <= 1'h1;
    cmd_code  <= code;
    cmd_sect  <= sect;
    #1;
    wait_ready();
    @(posedge mclk_in);
    cmd_valid <= 1'h0;
    #1;
  endtask : issue
  // ------------------------------------------------------------
  // ordinary operations: code, mask, expected mask/erase/run/pll
  // ------------------------------------------------------------
  typedef struct {logic [2:0] code, sect, xs; logic xe, xrun, xpll;} fpmc_row_t;
  fpmc_row_t rows[6];
  logic [23:0] img[5];
  logic [1:0] xrole[5];
  initial begin
    rows[0] = '{FPMC_CMD_OFF_ERASE, 3'h0, `FPMC_MASK_OFFLINE_DEF, 1'h1, 1'h0, 1'h0};
    rows[1] = '{FPMC_CMD_OFF_PROG, 3'h0, `FPMC_MASK_OFFLINE_DEF, 1'h0, 1'h0, 1'h0};
    rows[2] = '{FPMC_CMD_OFF_PROG, 3'h2, 3'h2, 1'h0, 1'h0, 1'h0};
    rows[3] = '{FPMC_CMD_BG_ERASE, 3'h0, `FPMC_MASK_BG_DEF, 1'h1, 1'h1, 1'h1};
    rows[4] = '{FPMC_CMD_BG_PROG, 3'h0, `FPMC_MASK_BG_DEF, 1'h0, 1'h1, 1'h0};
    rows[5] = '{FPMC_CMD_BG_PROG, 3'h7, `FPMC_MASK_BG_DEF, 1'h0, 1'h1, 1'h0};
    img = '{`FPMC_CFG_WORDS + `FPMC_UFM_WORDS + 24'h1, `FPMC_CFG_WORDS + 24'h1, 24'h10, 24'h10,
            `FPMC_CFG_WORDS + 24'h1};
    xrole = '{2'h0, FPMC_UFM_CFGEXT, FPMC_UFM_EBR, FPMC_UFM_GENERAL, FPMC_UFM_GENERAL};
    // reset, then init held low by an outside party
    repeat (11) @(posedge mclk_in);
    #1;
    chk("reset done", 8'h0, done);
    chk("reset init pull", 8'h1, oe);
    chk("reset run", 8'h0, run);
    @(posedge mclk_in);
    rst_in  <= 1'h0;
    ext_low <= 1'h1;
    repeat (30) @(posedge mclk_in);
    #1;
    chk("init held ready", 8'h0, ready);
    ext_low <= 1'h0;
    wait_ready();
    chk("first load", 8'h1, loads);
    $display("test reset ended");
    // table of flash operations, prompt and slow flash in turn
    @(posedge mclk_in);
    ib_req <= 1'h1;
    loads0 = loads;
    foreach (rows[i]) begin
      lat <= i[0] ? 4'h9 : 4'h0;
      issue(rows[i].code, rows[i].sect);
      chk("fl_req", 8'h1, fl_req);
      chk("fl_sect", {5'h0, rows[i].xs}, fl_sect);
      chk("fl_erase", {7'h0, rows[i].xe}, fl_erase);
      chk("user_run", {7'h0, rows[i].xrun}, run);
      chk("done", {7'h0, rows[i].xrun}, done);
      chk("pll_right", {7'h0, rows[i].xpll}, pll);
      chk("ib_err busy", 8'h1, ib_err);
      chk("ib_grant busy", 8'h0, grant);
      @(posedge mclk_in);
      #1;
      chk("fl_req pulse", 8'h0, fl_req);
      wait_ready();
      chk("pll_right after", 8'h0, pll);
      chk("run after", 8'h1, run);
      chk("ib_grant user", 8'h1, grant);
      chk("ib_err user", 8'h0, ib_err);
    end
    chk("no reload", loads0, loads);
    $display("test flash operations ended");
    // undefined codes are refused with a one cycle error
    foreach (img[i]) begin
      if (i < 3) begin
        issue(i == 0 ? 3'h0 : 3'h5 + i[2:0], 3'h0);
        chk("cmd_err", 8'h1, err);
        chk("no flash op", 8'h0, fl_req);
        @(posedge mclk_in);
        #1;
        chk("cmd_err pulse", 8'h0, err);
        wait_ready();
      end
    end
    $display("test bad codes ended");
    // refresh with image sizes that pick the load source and user sector role
    foreach (img[i]) begin
      image_words <= img[i];
      embedded_block_ram         <= (i == 2);
      blk         <= (i == 4);
      loads0 = loads;
      issue(FPMC_CMD_REFRESH, 3'h0);
      chk("refresh done", 8'h0, done);
      chk("refresh run", 8'h0, run);
      chk("refresh init", 8'h1, oe);
      wait_ready();
      chk("reload", loads0 + 8'h1, loads);
      chk("ext source", {7'h0, i == 0 || i == 4}, src_ext);
      if (i > 0) chk("ufm role", {6'h0, xrole[i]}, {6'h0, role});
    end
    $display("test refresh ended");
    // reset in the middle of a slow background erase
    issue(FPMC_CMD_BG_ERASE, 3'h0);
    @(posedge mclk_in);
    rst_in <= 1'h1;
    repeat (4) @(posedge mclk_in);
    #1;
    chk("mid reset done", 8'h0, done);
    chk("mid reset init pull", 8'h1, oe);
    chk("mid reset run", 8'h0, run);
    chk("mid reset pll", 8'h0, pll);
    chk("mid reset ready", 8'h0, ready);
    @(posedge mclk_in);
    rst_in <= 1'h0;
    wait_ready();
    chk("mid reset load", 8'h1, loads);
    chk("mid reset grant", 8'h1, grant);
    $display("test mid reset ended");
    tally_and_finish();
  end
endmodule : flash_program_mode_control_tb

// ---- testbench/fpmc_host_model.sv ----
// flash array and configuration loader model facing the controller
`timescale 1ns/1ns
module fpmc_host_model (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // answer delay in cycles, 0 answers promptly
  input  wire logic [3:0] lat_in,
  // flash array side
  input  wire logic       fl_req_in,
  output logic            fl_done_out,
  // SRAM load side
  input  wire logic       cfg_load_in,
  output logic            cfg_loaded_out,
  output logic [7:0]      load_count_out
);
  logic [4:0] fl_cnt;
  logic [4:0] ld_cnt;
  // ------------------------------------------------------------
  // flash sectors answer each start pulse once, after the delay
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    fl_done_out <= 1'h0;
    if (rst_in) begin
      fl_cnt <= 5'h00;
    end else if (fl_req_in) begin
      fl_cnt <= {1'h0, lat_in} + 5'h01;
    end else if (fl_cnt != 5'h00) begin
      fl_cnt      <= fl_cnt - 5'h01;
      fl_done_out <= (fl_cnt == 5'h01);
    end
  end
  // ------------------------------------------------------------
  // whole image reload into SRAM, counted so stray loads show
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    cfg_loaded_out <= 1'h0;
    if (rst_in) begin
      ld_cnt         <= 5'h00;
      load_count_out <= 8'h00;
    end else if (cfg_load_in) begin
      ld_cnt         <= {1'h0, lat_in} + 5'h01;
      load_count_out <= load_count_out + 8'h01;
    end else if (ld_cnt != 5'h00) begin
      ld_cnt         <= ld_cnt - 5'h01;
      cfg_loaded_out <= (ld_cnt == 5'h01);
    end
  end
endmodule : fpmc_host_model
